// ---- bench/test_cpu_address_mode_control.sv ----
// Self-checking bench for the address and mode control block
`timescale 1ns/10ps
module test_cpu_address_mode_control
   import cpuamc_pkg::*;
;
   // ======================================================
   // Stimulus signals
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   cpuamc_sfr_type sfr = '0;
   cpuamc_bit_type bitwr = '0;
   logic work_load = 1'b0;
   logic [7:0] work_load_val = 8'h00;
   logic aux_load = 1'b0;
   logic [7:0] aux_load_val = 8'h00;
   logic psw_load = 1'b0;
   cpuamc_psw_type psw_load_val = '0;
   logic stack_push = 1'b0;
   logic stack_pop = 1'b0;
   logic high_prio_active = 1'b0;
   logic low_prio_active = 1'b0;
   logic internal_fast_osc = 1'b0;
   logic fetch_req = 1'b0;
   logic [7:0] fetch_data = 8'h00;
   logic movx_ri = 1'b0;
   logic [7:0] ri_low = 8'h00;
   logic [7:0] port_two_latch = 8'h00;
   logic [7:0] sfr_rdata;
   logic [15:0] stack_addr;
   logic [23:0] xram_addr;
   logic [23:0] xram_base;
   logic [15:0] vector_base;
   logic flat_mode;
   logic fetch_stall;
   logic fetch_valid;
   logic [7:0] fetch_q;
   int err_total = 0;
   int check_count = 0;
   int n0, n1, n2;

   always #5 mclk = ~mclk;

   cpuamc_core dut_u (.mclk, .rst_n, .sfr, .bitwr, .work_load, .work_load_val, .aux_load,
      .aux_load_val, .psw_load, .psw_load_val, .stack_push, .stack_pop, .high_prio_active,
      .low_prio_active, .internal_fast_osc, .fetch_req, .fetch_data, .movx_ri, .ri_low,
      .port_two_latch, .sfr_rdata, .stack_addr, .xram_addr, .xram_base, .vector_base,
      .flat_mode, .fetch_stall, .fetch_valid, .fetch_q);

   // ======================================================
   // Shared tasks
   task automatic finish_test;
      if (err_total == 0 && check_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic check(input logic [23:0] seen, input logic [23:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge mclk);
      sfr = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(negedge mclk);
      sfr = '0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(negedge mclk);
      sfr = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(negedge mclk);
      sfr = '0;
      check({16'h0000, sfr_rdata}, {16'h0000, e});
   endtask

   // Unlock pair followed at once by the protected write, inside the window
   task automatic prot(input logic [7:0] a, input logic [7:0] d);
      wr(ADDR_TIMED, UNLOCK_FIRST);
      wr(ADDR_TIMED, UNLOCK_SECOND);
      wr(a, d);
   endtask

   task automatic settle;
      repeat (2) @(negedge mclk);
   endtask

   // ======================================================
   // Scenarios
   task automatic reset_values;
      rd(ADDR_WORK, 8'h00);
      rd(ADDR_AUX, 8'h00);
      rd(ADDR_PSW, 8'h00);
      rd(ADDR_WAIT, 8'h07);
      rd(ADDR_MODE_CTRL, 8'h00);
      rd(ADDR_XRAM_BASE, 8'h00);
      rd(ADDR_SP_LOW, 8'h00);
      rd(ADDR_SP_HIGH, 8'h00);
      rd(ADDR_INT_STATUS, 8'h00);
      rd(ADDR_RI_PAGE, 8'h00);
      rd(ADDR_RI_TOP, 8'h00);
      check({8'h00, vector_base}, 24'h000000);
   endtask

   task automatic work_regs;
      wr(ADDR_WORK, 8'h3C);
      rd(ADDR_WORK, 8'h3C);
      @(negedge mclk);
      bitwr = '{wr: 1'b1, addr: ADDR_WORK, wdata: 8'h81};
      @(negedge mclk);
      bitwr = '0;
      rd(ADDR_WORK, 8'hBD);
      @(negedge mclk);
      bitwr = '{wr: 1'b1, addr: ADDR_AUX, wdata: 8'h10};
      aux_load = 1'b1;
      aux_load_val = 8'h0F;
      @(negedge mclk);
      bitwr = '0;
      aux_load = 1'b0;
      rd(ADDR_AUX, 8'h0F);
      wr(ADDR_AUX, 8'hA6);
      rd(ADDR_AUX, 8'hA6);
      @(negedge mclk);
      bitwr = '{wr: 1'b1, addr: ADDR_AUX, wdata: 8'h01};
      @(negedge mclk);
      bitwr = '0;
      rd(ADDR_AUX, 8'hA7);
      @(negedge mclk);
      psw_load = 1'b1;
      psw_load_val = '{carry_flag: 1'b1, half_carry_flag: 1'b0, user_flag_zero: 1'b1,
         register_bank_select: 2'b10, arith_excess_flag: 1'b0, reserved_user_bit: 1'b1,
         parity: 1'b1};
      work_load = 1'b1;
      work_load_val = 8'h5A;
      @(negedge mclk);
      psw_load = 1'b0;
      work_load = 1'b0;
      rd(ADDR_PSW, 8'hB3);
      rd(ADDR_WORK, 8'h5A);
   endtask

   task automatic status_ro;
      high_prio_active = 1'b1;
      settle();
      rd(ADDR_INT_STATUS, 8'h40);
      high_prio_active = 1'b0;
      low_prio_active = 1'b1;
      wr(ADDR_INT_STATUS, 8'hFF);
      rd(ADDR_INT_STATUS, 8'h20);
      low_prio_active = 1'b0;
   endtask

   task automatic protect;
      wr(ADDR_MODE_CTRL, 8'h02);
      wr(ADDR_XRAM_BASE, 8'h01);
      rd(ADDR_MODE_CTRL, 8'h00);
      rd(ADDR_XRAM_BASE, 8'h00);
      prot(ADDR_MODE_CTRL, 8'h02);
      settle();
      rd(ADDR_MODE_CTRL, 8'h06);
      check({23'h0, flat_mode}, 24'h000001);
      wr(ADDR_MODE_CTRL, 8'h00);
      rd(ADDR_MODE_CTRL, 8'h06);
      prot(ADDR_MODE_CTRL, 8'h20);
      settle();
      check({23'h0, flat_mode}, 24'h000000);
      check({8'h00, vector_base}, {8'h00, VECTOR_BOOT});
      rd(ADDR_MODE_CTRL, 8'h20);
      prot(ADDR_XRAM_BASE, 8'h03);
      settle();
      check(xram_base, 24'h001800);
      prot(ADDR_MODE_CTRL, 8'h00);
      settle();
      check({8'h00, vector_base}, {8'h00, VECTOR_NORMAL});
   endtask

   task automatic stack_ops;
      wr(ADDR_SP_LOW, 8'h07);
      @(negedge mclk);
      stack_push = 1'b1;
      @(negedge mclk);
      stack_push = 1'b0;
      check({8'h00, stack_addr}, 24'h000008);
      rd(ADDR_SP_LOW, 8'h08);
      @(negedge mclk);
      stack_pop = 1'b1;
      @(negedge mclk);
      stack_pop = 1'b0;
      check({8'h00, stack_addr}, 24'h000008);
      rd(ADDR_SP_LOW, 8'h07);
      prot(ADDR_MODE_CTRL, 8'h03);
      wr(ADDR_SP_HIGH, 8'h12);
      settle();
      check({16'h0000, stack_addr[15:8]}, 24'h000012);
      rd(ADDR_MODE_CTRL, 8'h07);
      wr(ADDR_SP_LOW, 8'hFF);
      @(negedge mclk);
      stack_push = 1'b1;
      @(negedge mclk);
      stack_push = 1'b0;
      check({8'h00, stack_addr}, 24'h001300);
      rd(ADDR_SP_HIGH, 8'h13);
   endtask

   // Cycles from request to data, with a bounded wait
   task automatic fetch(input logic [3:0] w, input logic osc, output int n);
      wr(ADDR_WAIT, {4'h0, w});
      internal_fast_osc = osc;
      fetch_data = 8'hC3 ^ {4'h0, w};
      @(negedge mclk);
      fetch_req = 1'b1;
      @(negedge mclk);
      fetch_req = 1'b0;
      check({23'h0, fetch_stall}, {23'h0, (w != 4'h0) || osc});
      n = 1;
      while (fetch_valid !== 1'b1) begin
         if (n > 30) begin
            err_total++;
            finish_test();
         end
         @(negedge mclk);
         n++;
      end
      check({16'h0000, fetch_q}, {16'h0000, fetch_data});
      check({23'h0, fetch_stall}, 24'h000000);
   endtask

   task automatic wait_states;
      fetch(4'h0, 1'b0, n0);
      fetch(4'h2, 1'b0, n1);
      check(n1[23:0], n0[23:0] + 24'd2);
      fetch(4'h0, 1'b1, n2);
      check(n2[23:0], n0[23:0] + 24'd1);
      rd(ADDR_WAIT, 8'h00);
   endtask

   task automatic ext_addr;
      wr(ADDR_PTR0_LOW, 8'h11);
      wr(ADDR_PTR0_HIGH, 8'h22);
      wr(ADDR_PTR0_TOP, 8'h33);
      wr(ADDR_PTR1_LOW, 8'hA1);
      wr(ADDR_PTR1_HIGH, 8'hB2);
      wr(ADDR_PTR1_TOP, 8'hC3);
      wr(ADDR_RI_TOP, 8'h77);
      wr(ADDR_RI_PAGE, 8'h44);
      wr(ADDR_PTR_SELECT, 8'h00);
      settle();
      check(xram_addr, 24'h332211);
      wr(ADDR_PTR_SELECT, 8'h01);
      settle();
      check(xram_addr, 24'hC3B2A1);
      rd(ADDR_PTR_SELECT, 8'h01);
      movx_ri = 1'b1;
      ri_low = 8'h5A;
      port_two_latch = 8'h3C;
      settle();
      check(xram_addr, 24'h773C5A);
      prot(ADDR_MODE_CTRL, 8'h08);
      settle();
      check(xram_addr, 24'h77445A);
      movx_ri = 1'b0;
      settle();
      check(xram_addr, 24'hC3B2A1);
   endtask

   // ======================================================
   // Main sequence
   initial begin
      repeat (3) @(negedge mclk);
      rst_n = 1'b1;
      reset_values();
      work_regs();
      status_ro();
      protect();
      stack_ops();
      wait_states();
      ext_addr();
      finish_test();
   end
endmodule

// ---- rtl/cpuamc_core.sv ----
// Core register file, stack, wait-state and external address formation
`timescale 1ns/10ps
// Summary of operation
// [RULE_01] Working register resets to zero, is a core operand, bit addressable.
// [RULE_02] Auxiliary register holds multiply/divide operand, scratch otherwise, bit addressable.
// [RULE_03] Status word: carry 7, half carry 6, user 5, bank 4:3, excess 2, user 1, parity 0.
// [RULE_04] Push writes at stack pointer plus one; pop reads at stack pointer.
// [RULE_05] Flat mode joins stack high byte above low byte into 16-bit stack address.
// [RULE_06] Read-only status: bit 6 high-priority active, bit 5 low-priority active.
// [RULE_07] Software reads progress status before entering low-power or slow modes.
// [RULE_08] Wait-state field bits 3:0 sets flash access periods, resets to seven.
// [RULE_09] With fast oscillator at high rate, wait value zero acts as one.
// [RULE_10] Software programs more than one wait state above the stated clock.
// [RULE_11] XRAM base register moves XRAM start in fixed 2KB steps.
// [RULE_12] Large mode 16-bit program addresses; flat mode 20-bit, stack in data space.
// [RULE_13] Mode field bits 1:0: zero is large, upper bit set is flat.
// [RULE_14] Read-only stack indicator bit 2: zero internal stack, one extended stack.
// [RULE_15] Vector relocation bit 5 selects boot vector space or normal low space.
// [RULE_16] Bit 3 chooses port two latch or page register for register-indirect page.
// [RULE_17] Register-indirect top register gives bits 23:16 only for register-indirect moves.
// [RULE_18] Pointer moves use selected pointer high, low and top bytes.
// [RULE_19] External data address path is 24 bits wide.
// [RULE_20] Two independent data pointers, chosen by the pointer-select register.
// [RULE_21] Mode and XRAM base registers reset to zero, written only under timed access.
// [RULE_22] Select bit set picks second pointer, clear picks first; reads back selection.
// [RULE_23] Each flash fetch stalls the programmed wait cycles before latching data.
// [RULE_24] Timed access opens a short window after fixed unlock writes; else ignored.
module cpuamc_core
   import cpuamc_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire cpuamc_sfr_type sfr,
   input wire cpuamc_bit_type bitwr,
   input wire logic work_load,
   input wire logic [7:0] work_load_val,
   input wire logic aux_load,
   input wire logic [7:0] aux_load_val,
   input wire logic psw_load,
   input wire cpuamc_psw_type psw_load_val,
   input wire logic stack_push,
   input wire logic stack_pop,
   input wire logic high_prio_active,
   input wire logic low_prio_active,
   input wire logic internal_fast_osc,
   input wire logic fetch_req,
   input wire logic [7:0] fetch_data,
   input wire logic movx_ri,
   input wire logic [7:0] ri_low,
   input wire logic [7:0] port_two_latch,
   output logic [7:0] sfr_rdata,
   output logic [15:0] stack_addr,
   output logic [23:0] xram_addr,
   output logic [23:0] xram_base,
   output logic [15:0] vector_base,
   output logic flat_mode,
   output logic fetch_stall,
   output logic fetch_valid,
   output logic [7:0] fetch_q
);
   logic [7:0] work_q, aux_q, sp_q, sph_q, wait_q, mode_q, xbase_q, page_q, top_q;
   logic [7:0] ptrsel_q, status_q;
   logic [7:0] p0l_q, p0h_q, p0x_q, p1l_q, p1h_q, p1x_q;
   cpuamc_psw_type psw_q;
   logic [1:0] ta_stage_q;
   logic [2:0] ta_cnt_q;
   logic [3:0] ws_cnt_q;
   logic busy_q;
   logic [7:0] rd_d;
   logic ta_open;
   logic [3:0] wait_eff;
   logic flat_d;

   // ==================================================================
   // Decode helpers
   function automatic logic hit(input logic [7:0] a, input logic [7:0] reg_addr);
      hit = (a == reg_addr);
   endfunction

   logic sfr_wr_work, sfr_wr_aux, sfr_wr_psw;
   assign sfr_wr_work = sfr.wr && hit(sfr.addr, ADDR_WORK);
   assign sfr_wr_aux = sfr.wr && hit(sfr.addr, ADDR_AUX);
   assign sfr_wr_psw = sfr.wr && hit(sfr.addr, ADDR_PSW);
   assign ta_open = (ta_cnt_q != 3'h0);
   assign flat_d = mode_q[MODE_FLAT_BIT]; // [RULE_13]

   // ==================================================================
   // Bit-addressable core registers; bit writes give a byte mask
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         work_q <= BYTE_ZERO; // [RULE_01]
      end else if (work_load) begin
         work_q <= work_load_val;
      end else if (sfr_wr_work) begin
         work_q <= sfr.wdata;
      end else if (bitwr.wr && hit(bitwr.addr, ADDR_WORK)) begin
         work_q <= work_q ^ bitwr.wdata; // [RULE_01]
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         aux_q <= BYTE_ZERO;
      end else if (aux_load) begin
         aux_q <= aux_load_val; // [RULE_02]
      end else if (sfr_wr_aux) begin
         aux_q <= sfr.wdata;
      end else if (bitwr.wr && hit(bitwr.addr, ADDR_AUX)) begin
         aux_q <= aux_q ^ bitwr.wdata; // [RULE_02]
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         psw_q <= '0;
      end else if (psw_load) begin
         psw_q <= psw_load_val; // [RULE_03]
      end else if (sfr_wr_psw) begin
         psw_q <= cpuamc_psw_type'(sfr.wdata); // [RULE_03]
      end else if (bitwr.wr && hit(bitwr.addr, ADDR_PSW)) begin
         psw_q <= cpuamc_psw_type'(psw_q ^ bitwr.wdata);
      end
   end

   // ==================================================================
   // Stack pointer: push increments before write, pop decrements after read
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         sp_q <= BYTE_ZERO;
         sph_q <= BYTE_ZERO;
      end else if (stack_push) begin
         {sph_q, sp_q} <= flat_d ? 16'({sph_q, sp_q} + 16'h0001) :
                          {sph_q, 8'(sp_q + 8'h01)}; // [RULE_04]
      end else if (stack_pop) begin
         {sph_q, sp_q} <= flat_d ? 16'({sph_q, sp_q} - 16'h0001) : {sph_q, 8'(sp_q - 8'h01)};
      end else if (sfr.wr && hit(sfr.addr, ADDR_SP_LOW)) begin
         sp_q <= sfr.wdata;
      end else if (sfr.wr && hit(sfr.addr, ADDR_SP_HIGH)) begin
         sph_q <= sfr.wdata;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         stack_addr <= 16'h0000;
      end else if (flat_d) begin
         stack_addr <= stack_push ? 16'({sph_q, sp_q} + 16'h0001) : {sph_q, sp_q}; // [RULE_05]
      end else begin
         stack_addr <= {BYTE_ZERO, stack_push ? 8'(sp_q + 8'h01) : sp_q}; // [RULE_04]
      end
   end

   // ==================================================================
   // Timed access: two unlock writes open a few-cycle window
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         ta_stage_q <= 2'h0;
         ta_cnt_q <= 3'h0;
      end else if (sfr.wr && hit(sfr.addr, ADDR_TIMED)) begin
         if (sfr.wdata == UNLOCK_FIRST) begin
            ta_stage_q <= 2'h1;
            ta_cnt_q <= 3'h0;
         end else if (ta_stage_q == 2'h1 && sfr.wdata == UNLOCK_SECOND) begin
            ta_stage_q <= 2'h0;
            ta_cnt_q <= TA_WINDOW; // [RULE_24]
         end else begin
            ta_stage_q <= 2'h0;
            ta_cnt_q <= 3'h0;
         end
      end else if (sfr.wr && ta_open &&
                   (hit(sfr.addr, ADDR_MODE_CTRL) || hit(sfr.addr, ADDR_XRAM_BASE))) begin
         ta_cnt_q <= 3'h0; // One protected write per unlock
      end else if (ta_open) begin
         ta_cnt_q <= 3'(ta_cnt_q - 3'h1);
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         mode_q <= BYTE_ZERO; // [RULE_21]
         xbase_q <= BYTE_ZERO;
      end else begin
         if (sfr.wr && ta_open && hit(sfr.addr, ADDR_MODE_CTRL)) begin
            mode_q <= (sfr.wdata & MODE_CTRL_WMASK) |
                      (sfr.wdata[MODE_FLAT_BIT] ? 8'h01 << MODE_STACK_BIT : 8'h00); // [RULE_14]
         end
         if (sfr.wr && ta_open && hit(sfr.addr, ADDR_XRAM_BASE)) begin
            xbase_q <= sfr.wdata; // [RULE_21]
         end
      end
   end

   // ==================================================================
   // Plain registers: wait states, page, top bytes, pointers
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         wait_q <= WAIT_RESET; // [RULE_08]
         page_q <= BYTE_ZERO;
         top_q <= BYTE_ZERO;
      end else if (sfr.wr) begin
         if (hit(sfr.addr, ADDR_WAIT)) wait_q <= {4'h0, sfr.wdata[3:0]}; // [RULE_08]
         if (hit(sfr.addr, ADDR_RI_PAGE)) page_q <= sfr.wdata; // [RULE_16]
         if (hit(sfr.addr, ADDR_RI_TOP)) top_q <= sfr.wdata; // [RULE_17]
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         p0l_q <= BYTE_ZERO;
         p0h_q <= BYTE_ZERO;
         p0x_q <= BYTE_ZERO;
         p1l_q <= BYTE_ZERO;
         p1h_q <= BYTE_ZERO;
         p1x_q <= BYTE_ZERO;
         ptrsel_q <= BYTE_ZERO;
      end else if (sfr.wr) begin
         if (hit(sfr.addr, ADDR_PTR0_LOW)) p0l_q <= sfr.wdata; // [RULE_20]
         if (hit(sfr.addr, ADDR_PTR0_HIGH)) p0h_q <= sfr.wdata;
         if (hit(sfr.addr, ADDR_PTR0_TOP)) p0x_q <= sfr.wdata;
         if (hit(sfr.addr, ADDR_PTR1_LOW)) p1l_q <= sfr.wdata;
         if (hit(sfr.addr, ADDR_PTR1_HIGH)) p1h_q <= sfr.wdata;
         if (hit(sfr.addr, ADDR_PTR1_TOP)) p1x_q <= sfr.wdata;
         if (hit(sfr.addr, ADDR_PTR_SELECT)) ptrsel_q <= sfr.wdata & PTR_SEL_WMASK; // [RULE_22]
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         status_q <= BYTE_ZERO;
      end else begin
         // Pins from the interrupt controller share mclk, so no synchroniser
         status_q <= ({1'b0, high_prio_active, low_prio_active, 5'h00}) & STATUS_WMASK; // [RULE_06]
      end
   end

   // ==================================================================
   // External data address, 24 bits
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         xram_addr <= 24'h000000;
      end else if (movx_ri) begin
         xram_addr <= {top_q, mode_q[MODE_PAGE_SRC_BIT] ? page_q : port_two_latch,
                       ri_low}; // [RULE_16] [RULE_17] [RULE_19]
      end else if (ptrsel_q[PTR_SEL_BIT]) begin
         xram_addr <= {p1x_q, p1h_q, p1l_q}; // [RULE_18] [RULE_22]
      end else begin
         xram_addr <= {p0x_q, p0h_q, p0l_q}; // [RULE_18]
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         xram_base <= 24'h000000;
         vector_base <= VECTOR_NORMAL;
         flat_mode <= 1'b0;
      end else begin
         xram_base <= 24'(xbase_q) << XRAM_STEP_SHIFT; // [RULE_11]
         vector_base <= mode_q[MODE_VECTOR_BIT] ? VECTOR_BOOT : VECTOR_NORMAL; // [RULE_15]
         flat_mode <= flat_d; // [RULE_12]
      end
   end

   // ==================================================================
   // Flash fetch wait states
   assign wait_eff = (internal_fast_osc && wait_q[3:0] == WAIT_ZERO) ? WAIT_ONE :
                     wait_q[3:0]; // [RULE_09]

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         busy_q <= 1'b0;
         ws_cnt_q <= WAIT_ZERO;
         fetch_stall <= 1'b0;
         fetch_valid <= 1'b0;
         fetch_q <= BYTE_ZERO;
      end else begin
         fetch_valid <= 1'b0;
         if (!busy_q && fetch_req) begin
            if (wait_eff == WAIT_ZERO) begin
               fetch_q <= fetch_data;
               fetch_valid <= 1'b1;
            end else begin
               busy_q <= 1'b1;
               ws_cnt_q <= wait_eff; // [RULE_23]
               fetch_stall <= 1'b1;
            end
         end else if (busy_q) begin
            if (ws_cnt_q == WAIT_ONE) begin
               busy_q <= 1'b0;
               fetch_stall <= 1'b0;
               fetch_q <= fetch_data; // [RULE_23]
               fetch_valid <= 1'b1;
            end else begin
               ws_cnt_q <= ws_cnt_q - WAIT_ONE;
            end
         end
      end
   end

   // ==================================================================
   // Read mux; unmapped reads return zero
   always_comb begin
      rd_d = BYTE_ZERO;
      if (hit(sfr.addr, ADDR_WORK)) rd_d = work_q;
      else if (hit(sfr.addr, ADDR_AUX)) rd_d = aux_q;
      else if (hit(sfr.addr, ADDR_PSW)) rd_d = psw_q;
      else if (hit(sfr.addr, ADDR_SP_LOW)) rd_d = sp_q;
      else if (hit(sfr.addr, ADDR_SP_HIGH)) rd_d = sph_q;
      else if (hit(sfr.addr, ADDR_WAIT)) rd_d = wait_q;
      else if (hit(sfr.addr, ADDR_MODE_CTRL)) rd_d = mode_q;
      else if (hit(sfr.addr, ADDR_XRAM_BASE)) rd_d = xbase_q;
      else if (hit(sfr.addr, ADDR_INT_STATUS)) rd_d = status_q; // [RULE_06]
      else if (hit(sfr.addr, ADDR_RI_PAGE)) rd_d = page_q;
      else if (hit(sfr.addr, ADDR_RI_TOP)) rd_d = top_q;
      else if (hit(sfr.addr, ADDR_PTR0_LOW)) rd_d = p0l_q;
      else if (hit(sfr.addr, ADDR_PTR0_HIGH)) rd_d = p0h_q;
      else if (hit(sfr.addr, ADDR_PTR0_TOP)) rd_d = p0x_q;
      else if (hit(sfr.addr, ADDR_PTR1_LOW)) rd_d = p1l_q;
      else if (hit(sfr.addr, ADDR_PTR1_HIGH)) rd_d = p1h_q;
      else if (hit(sfr.addr, ADDR_PTR1_TOP)) rd_d = p1x_q;
      else if (hit(sfr.addr, ADDR_PTR_SELECT)) rd_d = ptrsel_q; // [RULE_22]
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         sfr_rdata <= BYTE_ZERO;
      end else if (sfr.rd) begin
         sfr_rdata <= rd_d;
      end
   end

   // ==================================================================
   // Checks
   sequence s_unlock;
      sfr.wr && sfr.addr == ADDR_TIMED && sfr.wdata == UNLOCK_FIRST ##1 !sfr.wr ##1
      sfr.wr && sfr.addr == ADDR_TIMED && sfr.wdata == UNLOCK_SECOND;
   endsequence

   a_mode_locked: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE_21]
      (sfr.wr && sfr.addr == ADDR_MODE_CTRL && !ta_open) |=> $stable(mode_q))
      else $error("mode control written without timed access");
   a_unlock_opens: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE_24]
      s_unlock |=> ta_open)
      else $error("unlock sequence did not open window");
   a_stack_ind: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE_14]
      mode_q[MODE_STACK_BIT] == mode_q[MODE_FLAT_BIT])
      else $error("stack indicator disagrees with mode");
   a_wait_reset: assert property (@(posedge mclk) // [RULE_08]
      !rst_n |=> wait_q == WAIT_RESET)
      else $error("wait states not seven after reset");
   a_fetch_stall: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE_23]
      (fetch_req && !busy_q && wait_eff == WAIT_ONE) |=> fetch_stall ##1 fetch_valid)
      else $error("single wait state fetch timing wrong");
   a_fast_osc: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE_09]
      (internal_fast_osc && fetch_req && !busy_q) |=> !fetch_valid)
      else $error("zero wait state honoured at fast oscillator");
   a_push_addr: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE_04]
      (stack_push && !flat_d) |=> stack_addr[7:0] == sp_q)
      else $error("push address not stack pointer plus one");
   a_ri_top: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE_17]
      movx_ri |=> xram_addr[23:16] == $past(top_q))
      else $error("register-indirect top byte wrong");
   a_ptr_sel: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE_18]
      (!movx_ri && ptrsel_q[PTR_SEL_BIT]) |=> xram_addr == $past({p1x_q, p1h_q, p1l_q}))
      else $error("second pointer address wrong");
   a_status: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE_06]
      high_prio_active |=> status_q[STATUS_HIGH_BIT])
      else $error("high priority status missing");
endmodule

// ---- rtl/cpuamc_pkg.sv ----
// Package: register offsets, field positions, reset values and carriers for the address/mode block
package cpuamc_pkg;
   localparam logic [7:0] ADDR_SP_LOW = 8'h81;
   localparam logic [7:0] ADDR_PTR0_LOW = 8'h82;
   localparam logic [7:0] ADDR_PTR0_HIGH = 8'h83;
   localparam logic [7:0] ADDR_PTR1_LOW = 8'h84;
   localparam logic [7:0] ADDR_PTR1_HIGH = 8'h85;
   localparam logic [7:0] ADDR_PTR_SELECT = 8'h86;
   localparam logic [7:0] ADDR_WAIT = 8'h92;
   localparam logic [7:0] ADDR_PTR0_TOP = 8'h93;
   localparam logic [7:0] ADDR_PTR1_TOP = 8'h95;
   localparam logic [7:0] ADDR_SP_HIGH = 8'h9B;
   localparam logic [7:0] ADDR_MODE_CTRL = 8'h9D;
   localparam logic [7:0] ADDR_PORT_TWO = 8'hA0;
   localparam logic [7:0] ADDR_TIMED = 8'hC7;
   localparam logic [7:0] ADDR_INT_STATUS = 8'hC5;
   localparam logic [7:0] ADDR_XRAM_BASE = 8'hC6;
   localparam logic [7:0] ADDR_PSW = 8'hD0;
   localparam logic [7:0] ADDR_RI_PAGE = 8'hDA;
   localparam logic [7:0] ADDR_WORK = 8'hE0;
   localparam logic [7:0] ADDR_RI_TOP = 8'hEA;
   localparam logic [7:0] ADDR_AUX = 8'hF0;

   localparam logic [7:0] WAIT_RESET = 8'h07;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [3:0] WAIT_ZERO = 4'h0;
   localparam logic [3:0] WAIT_ONE = 4'h1;
   localparam logic [7:0] MODE_CTRL_WMASK = 8'h2B;
   localparam logic [7:0] PTR_SEL_WMASK = 8'hE1;
   localparam logic [7:0] STATUS_WMASK = 8'h60;

   localparam int MODE_VECTOR_BIT = 5;
   localparam int MODE_PAGE_SRC_BIT = 3;
   localparam int MODE_STACK_BIT = 2;
   localparam int MODE_FLAT_BIT = 1;
   localparam int STATUS_HIGH_BIT = 6;
   localparam int STATUS_LOW_BIT = 5;
   localparam int PTR_SEL_BIT = 0;

   localparam logic [7:0] UNLOCK_FIRST = 8'hAA;
   localparam logic [7:0] UNLOCK_SECOND = 8'h55;
   localparam logic [2:0] TA_WINDOW = 3'h4;

   localparam logic [15:0] VECTOR_BOOT = 16'h3000;
   localparam logic [15:0] VECTOR_NORMAL = 16'h0000;
   localparam int XRAM_STEP_SHIFT = 11;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } cpuamc_sfr_type;

   typedef struct packed {
      logic wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } cpuamc_bit_type;

   typedef struct packed {
      logic carry_flag;
      logic half_carry_flag;
      logic user_flag_zero;
      logic [1:0] register_bank_select;
      logic arith_excess_flag;
      logic reserved_user_bit;
      logic parity;
   } cpuamc_psw_type;
endpackage
